/* sbc_pkg.sv */
// constants, field positions and mode encodings of the mode sequencer
package sbc_pkg;

  // operating modes
  typedef enum logic [2:0] {
    SBC_RESET  = 3'b000,
    SBC_NREQ   = 3'b001,
    SBC_NORMAL = 3'b010,
    SBC_STOP   = 3'b011,
    SBC_SLEEP  = 3'b100
  } sbc_mode_e;

  // mode_select_bits command codes
  localparam logic [1:0] SBC_CMD_NORMAL = 2'h0;
  localparam logic [1:0] SBC_CMD_SLEEP  = 2'h1;
  localparam logic [1:0] SBC_CMD_STOP   = 2'h2;

  // clock and times in their own units
  localparam int unsigned SBC_CLK_HZ       = 250_000_000;
  localparam int unsigned SBC_RST_STRETCH_US = 1000;
  localparam int unsigned SBC_NREQ_MS      = 150;
  localparam int unsigned SBC_WD_MS        = 150;
  localparam int unsigned SBC_VDD_LOW_MS   = 150;

  // least time rounds up, longest rounds down (both exact at 250 MHz)
  localparam int unsigned SBC_RST_STRETCH_CYC =
    (SBC_RST_STRETCH_US * (SBC_CLK_HZ / 1000) + 999) / 1000;
  localparam int unsigned SBC_NREQ_CYC    = SBC_NREQ_MS * (SBC_CLK_HZ / 1000);
  localparam int unsigned SBC_WD_CYC      = SBC_WD_MS * (SBC_CLK_HZ / 1000);
  localparam int unsigned SBC_VDD_LOW_CYC =
    SBC_VDD_LOW_MS * (SBC_CLK_HZ / 1000);

  // reset pin glitch filter and readback blanking
  localparam int unsigned SBC_GLITCH_CYC = 16;
  localparam logic [1:0]  SBC_BLANK_CYC  = 2'h3;

  // wake_irq_source_reg layout
  localparam int unsigned SBC_SRC_W        = 12;
  localparam int unsigned SBC_SRC_LX       = 0;
  localparam int unsigned SBC_SRC_LIN_WAKE = 4;
  localparam int unsigned SBC_SRC_TMR_WAKE = 5;
  localparam int unsigned SBC_SRC_FLT      = 6;
  localparam int unsigned SBC_FLT_W        = 6;
  localparam logic [11:0] SBC_SRC_WAKE_MASK = 12'h03f;
  localparam logic [11:0] SBC_SRC_RST       = 12'h000;

  // fault order inside the fault field and irq_mask_reg
  localparam int unsigned SBC_FLT_UV   = 0;
  localparam int unsigned SBC_FLT_OV   = 1;
  localparam int unsigned SBC_FLT_PREW = 2;
  localparam int unsigned SBC_FLT_LIN  = 3;
  localparam int unsigned SBC_FLT_HS   = 4;
  localparam int unsigned SBC_FLT_LS   = 5;

endpackage : sbc_pkg

/* sbc_rst_if.sv */
// carrier between the reset pin filter and the mode sequencer
`timescale 1ns/1ps
`default_nettype none

interface sbc_rst_if;
  logic drive_blank;
  logic pin_low;
  logic cs_rise;
  modport filt (input drive_blank, output pin_low, output cs_rise);
  modport core (output drive_blank, input pin_low, input cs_rise);
endinterface : sbc_rst_if

`default_nettype wire

/* sbc_rst_filter.sv */
// synchroniser, glitch filter and edge detect for the reset and cs pins
`timescale 1ns/1ps
`default_nettype none

module sbc_rst_filter
  import sbc_pkg::*;
#(
  parameter int unsigned GLITCH_CYC = SBC_GLITCH_CYC
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic rst_pin_i,
  input  wire logic cs_n,
  sbc_rst_if.filt   rif
);

  logic [1:0]  rst_sync_q;
  logic [1:0]  cs_sync_q;
  logic        cs_prev_q;
  logic [1:0]  blank_q;
  logic [15:0] flt_cnt_q;
  logic        low_q;
  logic        rise_q;

  // two-flop synchronisers, first stage feeds only the second
  always_ff @(posedge clk) begin
    if (srst) begin
      rst_sync_q <= 2'h3;
      cs_sync_q  <= 2'h3;
    end else begin
      rst_sync_q <= {rst_sync_q[0], rst_pin_i};
      cs_sync_q  <= {cs_sync_q[0], cs_n};
    end
  end

  // own drive shows on readback a few cycles late, so blank after release
  always_ff @(posedge clk) begin
    if (srst) begin
      blank_q <= SBC_BLANK_CYC;
    end else if (rif.drive_blank) begin
      blank_q <= SBC_BLANK_CYC;
    end else if (blank_q != 2'h0) begin
      blank_q <= blank_q - 2'h1;
    end
  end

  // low must persist GLITCH_CYC cycles; release is seen at once
  always_ff @(posedge clk) begin
    if (srst) begin
      flt_cnt_q <= 16'h0000;
      low_q     <= 1'b0;
    end else if (rst_sync_q[1] || rif.drive_blank || blank_q != 2'h0) begin
      flt_cnt_q <= 16'h0000;
      low_q     <= 1'b0;
    end else if (flt_cnt_q >= 16'(GLITCH_CYC - 1)) begin
      low_q     <= 1'b1;
    end else begin
      flt_cnt_q <= flt_cnt_q + 16'h0001;
    end
  end

  // cs low-to-high edge, one-cycle pulse
  always_ff @(posedge clk) begin
    if (srst) begin
      cs_prev_q <= 1'b1;
      rise_q    <= 1'b0;
    end else begin
      cs_prev_q <= cs_sync_q[1];
      rise_q    <= cs_sync_q[1] & ~cs_prev_q;
    end
  end

  assign rif.pin_low = low_q;
  assign rif.cs_rise = rise_q;

endmodule : sbc_rst_filter

`default_nettype wire

/* sbc_mode_ctrl.sv */
// operating mode, wake, reset and interrupt sequencer of the basis chip
`timescale 1ns/1ps
`default_nettype none

module sbc_mode_ctrl
  import sbc_pkg::*;
#(
  parameter int unsigned RST_STRETCH_CYC = SBC_RST_STRETCH_CYC,
  parameter int unsigned NREQ_CYC        = SBC_NREQ_CYC,
  parameter int unsigned WD_CYC          = SBC_WD_CYC,
  parameter int unsigned VDD_LOW_CYC     = SBC_VDD_LOW_CYC,
  parameter int unsigned GLITCH_CYC      = SBC_GLITCH_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 mode_cmd_valid,
  input  wire logic [1:0]           mode_select_bits,
  input  wire logic                 timing_control_wr,
  input  wire logic                 isr_read,
  input  wire logic [SBC_FLT_W-1:0] irq_mask_reg,
  input  wire logic [3:0]           wake_control_reg,
  input  wire logic [3:0]           amux_input_sel,
  input  wire logic                 watchdog_config_pin,
  input  wire logic [3:0]           wake_inputs,
  input  wire logic                 lin_wake,
  input  wire logic                 timer_wake,
  input  wire logic                 cs_n,
  input  wire logic                 rst_pin_i,
  input  wire logic                 regulator_reset_level,
  input  wire logic                 regulator_overtemp,
  input  wire logic                 regulator_prewarn,
  input  wire logic                 supply_undervolt_level,
  input  wire logic                 supply_overvolt_level,
  input  wire logic                 lin_overtemp,
  input  wire logic                 lin_txd_stuck,
  input  wire logic                 lin_rxd_short,
  input  wire logic                 lin_txd_recessive,
  input  wire logic                 high_side_overtemp,
  input  wire logic                 low_side_overtemp,
  output sbc_mode_e                 mode_q,
  output logic                      rst_pin_o,
  output logic                      rst_pin_oe,
  output logic                      irq_n_q,
  output logic [SBC_SRC_W-1:0]      wake_irq_source_reg,
  output logic [3:0]                wake_status_reg,
  output logic                      regulator_overtemp_flag,
  output logic                      regulator_on_q,
  output logic                      regulator_limited_q,
  output logic                      supply_monitor_q,
  output logic                      lin_tx_en_q,
  output logic                      lin_rx_only_q,
  output logic                      lowpower_wake_only_q
);

  sbc_rst_if rif ();

  logic [31:0]          tmr_q;
  logic [31:0]          vdl_q;
  logic                 ext_q;
  logic                 wd_off_q;
  logic                 tim_seen_q;
  logic [3:0]           lx_ref_q;
  logic [3:0]           lx_arm_q;
  logic                 drive_q;
  logic [SBC_FLT_W-1:0] flt_prev_q;
  logic                 lin_dis_q;
  logic [SBC_SRC_W-1:0] src_q;
  logic                 ot_flag_q;

  logic                 ext_low;
  logic                 cmd_norm;
  logic                 cmd_sleep;
  logic                 cmd_stop;
  logic                 lin_fault;
  logic [3:0]           lx_wake;
  logic                 src_wake;
  logic                 wd_fail;
  logic [SBC_FLT_W-1:0] flt_now;
  logic [SBC_SRC_W-1:0] src_set;
  logic                 irq_evt;

  // true in the two low-power modes
  function automatic logic in_lowpower(input sbc_mode_e m);
    in_lowpower = (m == SBC_STOP) || (m == SBC_SLEEP);
  endfunction : in_lowpower

  // true where the device may pull the irq line low
  function automatic logic irq_mode(input sbc_mode_e m);
    irq_mode = (m == SBC_NORMAL) || (m == SBC_NREQ) || (m == SBC_STOP);
  endfunction : irq_mode

  sbc_rst_filter #(
    .GLITCH_CYC (GLITCH_CYC)
  ) u_filter (
    .clk        (clk),
    .srst       (srst),
    .rst_pin_i  (rst_pin_i),
    .cs_n       (cs_n),
    .rif        (rif.filt)
  );

  //////////////////////////////////////////////////////////////////////////
  // decode of commands, wake causes and faults

  assign ext_low   = rif.pin_low;
  assign cmd_norm  = mode_cmd_valid && (mode_select_bits == SBC_CMD_NORMAL);
  assign cmd_sleep = mode_cmd_valid && (mode_select_bits == SBC_CMD_SLEEP);
  assign cmd_stop  = mode_cmd_valid && (mode_select_bits == SBC_CMD_STOP);
  assign lin_fault = lin_overtemp | lin_txd_stuck | lin_rxd_short;

  // input wake: change against entry snapshot, enable and mux at entry
  assign lx_wake  = (wake_inputs ^ lx_ref_q) & lx_arm_q;
  assign src_wake = (|lx_wake) | lin_wake | timer_wake;

  // early service while window closed, or no service before overflow
  assign wd_fail = !wd_off_q &&
                   ((tmr_q >= 32'(WD_CYC - 1)) ||
                    (cmd_norm && (tmr_q < 32'(WD_CYC / 2))));

  assign flt_now = {low_side_overtemp, high_side_overtemp, lin_fault,
                    regulator_prewarn, supply_overvolt_level,
                    supply_undervolt_level};

  // sources that set a bit this cycle; cs and reset pin have none
  always_comb begin
    src_set = SBC_SRC_RST;
    if (in_lowpower(mode_q)) begin
      src_set[SBC_SRC_LX +: 4]     = lx_wake;
      src_set[SBC_SRC_LIN_WAKE]    = lin_wake;
      src_set[SBC_SRC_TMR_WAKE]    = timer_wake;
    end else if (mode_q == SBC_NORMAL || mode_q == SBC_NREQ) begin
      src_set[SBC_SRC_FLT +: SBC_FLT_W] = flt_now & ~flt_prev_q;
    end
  end

  // stop wakes interrupt; normal modes interrupt on unmasked faults
  always_comb begin
    irq_evt = 1'b0;
    if (mode_q == SBC_STOP) begin
      irq_evt = |(src_set & SBC_SRC_WAKE_MASK);
    end else if (mode_q == SBC_NORMAL || mode_q == SBC_NREQ) begin
      irq_evt = |(src_set[SBC_SRC_FLT +: SBC_FLT_W] & ~irq_mask_reg);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // mode sequencer; tmr_q is stretch, request timeout or watchdog

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_q <= SBC_RESET;
      tmr_q  <= 32'h0000_0000;
      ext_q  <= 1'b0;
    end else begin
      case (mode_q)
        SBC_RESET: begin
          if (ext_low) begin
            ext_q <= 1'b1;
            tmr_q <= 32'h0000_0000;
          end else if (regulator_reset_level && !supply_undervolt_level) begin
            mode_q <= SBC_SLEEP;
          end else if (regulator_reset_level || regulator_overtemp) begin
            tmr_q <= 32'h0000_0000;
          end else if (ext_q || tmr_q >= 32'(RST_STRETCH_CYC - 1)) begin
            mode_q <= watchdog_config_pin ? SBC_NORMAL : SBC_NREQ;
            tmr_q  <= 32'h0000_0000;
            ext_q  <= 1'b0;
          end else begin
            tmr_q <= tmr_q + 32'h0000_0001;
          end
        end
        SBC_NREQ: begin
          tmr_q <= tmr_q + 32'h0000_0001;
          if (ext_low) begin
            mode_q <= SBC_RESET;
            ext_q  <= 1'b1;
          end else if (regulator_reset_level) begin
            mode_q <= SBC_RESET;
            tmr_q  <= 32'h0000_0000;
          end else if (cmd_norm && tim_seen_q) begin
            mode_q <= SBC_NORMAL;
            tmr_q  <= 32'h0000_0000;
          end else if (tmr_q >= 32'(NREQ_CYC - 1)) begin
            mode_q <= SBC_RESET;
            tmr_q  <= 32'h0000_0000;
          end
        end
        SBC_NORMAL: begin
          tmr_q <= wd_off_q ? 32'h0000_0000 : tmr_q + 32'h0000_0001;
          if (ext_low) begin
            mode_q <= SBC_RESET;
            ext_q  <= 1'b1;
          end else if (regulator_reset_level && supply_undervolt_level) begin
            mode_q <= SBC_RESET;
            tmr_q  <= 32'h0000_0000;
          end else if (regulator_reset_level) begin
            if (vdl_q >= 32'(VDD_LOW_CYC - 1)) begin
              mode_q <= SBC_SLEEP;
            end
          end else if (vdl_q != 32'h0000_0000 || wd_fail) begin
            mode_q <= SBC_RESET;
            tmr_q  <= 32'h0000_0000;
          end else if (cmd_sleep) begin
            mode_q <= SBC_SLEEP;
          end else if (cmd_stop) begin
            mode_q <= SBC_STOP;
          end else if (cmd_norm) begin
            tmr_q <= 32'h0000_0000;
          end
        end
        SBC_STOP: begin
          tmr_q <= 32'h0000_0000;
          if (ext_low) begin
            mode_q <= SBC_RESET;
            ext_q  <= 1'b1;
          end else if (regulator_reset_level) begin
            mode_q <= SBC_RESET;
          end else if (src_wake || rif.cs_rise) begin
            mode_q <= SBC_NREQ;
          end
        end
        SBC_SLEEP: begin
          tmr_q <= 32'h0000_0000;
          if (src_wake) begin
            mode_q <= SBC_RESET;
          end
        end
        default: begin
          mode_q <= SBC_RESET;
          tmr_q  <= 32'h0000_0000;
          ext_q  <= 1'b0;
        end
      endcase
    end
  end

  // regulator-low time in normal mode
  always_ff @(posedge clk) begin
    if (srst || mode_q != SBC_NORMAL || !regulator_reset_level) begin
      vdl_q <= 32'h0000_0000;
    end else if (vdl_q != 32'hffff_ffff) begin
      vdl_q <= vdl_q + 32'h0000_0001;
    end
  end

  // strap and timing-write capture; strap only read while in reset
  always_ff @(posedge clk) begin
    if (srst) begin
      wd_off_q   <= 1'b0;
      tim_seen_q <= 1'b0;
    end else begin
      if (mode_q == SBC_RESET) begin
        wd_off_q <= watchdog_config_pin;
      end
      tim_seen_q <= (mode_q == SBC_NREQ) && (tim_seen_q || timing_control_wr);
    end
  end

  // wake input snapshot and arming, taken in the last cycle before low power
  always_ff @(posedge clk) begin
    if (srst) begin
      lx_ref_q <= 4'h0;
      lx_arm_q <= 4'h0;
    end else if (!in_lowpower(mode_q)) begin
      lx_ref_q <= wake_inputs;
      lx_arm_q <= wake_control_reg & ~amux_input_sel;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // reset pin drive; not started while the outside holds it low, but an outside low is blanked and unseen once driving

  always_ff @(posedge clk) begin
    if (srst) begin
      drive_q <= 1'b1;
    end else begin
      drive_q <= ((mode_q == SBC_RESET) && !ext_q && !ext_low) ||
                 (regulator_reset_level && !ext_low);
    end
  end

  assign rif.drive_blank = drive_q;
  assign rst_pin_o       = 1'b0;
  assign rst_pin_oe      = drive_q;

  //////////////////////////////////////////////////////////////////////////
  // source register and interrupt line; a set beats a read clear, at the line only with no wake bit pending

  always_ff @(posedge clk) begin
    if (srst) begin
      src_q      <= SBC_SRC_RST;
      flt_prev_q <= '0;
      irq_n_q    <= 1'b1;
    end else begin
      flt_prev_q <= flt_now;
      src_q      <= (isr_read ? SBC_SRC_RST : src_q) | src_set;
      if (!irq_mode(mode_q) || drive_q || ext_low) begin
        irq_n_q <= 1'b1;
      end else if (irq_evt && !(|(src_q & SBC_SRC_WAKE_MASK))) begin
        irq_n_q <= 1'b0;
      end else if (isr_read) begin
        irq_n_q <= 1'b1;
      end
    end
  end

  // regulator overtemperature flag, cleared by a read once gone
  always_ff @(posedge clk) begin
    if (srst) begin
      ot_flag_q <= 1'b0;
    end else if (regulator_overtemp) begin
      ot_flag_q <= 1'b1;
    end else if (isr_read) begin
      ot_flag_q <= 1'b0;
    end
  end

  // lin driver lockout until fault gone and txd back recessive
  always_ff @(posedge clk) begin
    if (srst) begin
      lin_dis_q <= 1'b0;
    end else if (lin_fault) begin
      lin_dis_q <= 1'b1;
    end else if (lin_txd_recessive) begin
      lin_dis_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // mode-dependent controls to the analog and lin blocks

  always_ff @(posedge clk) begin
    if (srst) begin
      regulator_on_q       <= 1'b1;
      regulator_limited_q  <= 1'b0;
      supply_monitor_q     <= 1'b1;
      lin_tx_en_q          <= 1'b0;
      lin_rx_only_q        <= 1'b0;
      lowpower_wake_only_q <= 1'b0;
      wake_status_reg      <= 4'h0;
    end else begin
      regulator_on_q <= (mode_q != SBC_SLEEP) && !regulator_overtemp;
      regulator_limited_q  <= (mode_q == SBC_STOP);
      supply_monitor_q     <= !in_lowpower(mode_q);
      lin_tx_en_q <= (mode_q == SBC_NORMAL) && !lin_dis_q && !lin_fault;
      lin_rx_only_q <= (mode_q == SBC_NREQ) || (mode_q == SBC_STOP);
      lowpower_wake_only_q <= in_lowpower(mode_q);
      wake_status_reg      <= wake_inputs;
    end
  end

  assign wake_irq_source_reg     = src_q;
  assign regulator_overtemp_flag = ot_flag_q;

endmodule : sbc_mode_ctrl

`default_nettype wire

/* sbc_rst_if_unused_note.sv */
// intentionally empty compile unit
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* sbc_mode_props.sv */
// port level checker of the mode sequencer
`timescale 1ns/1ps
`default_nettype none

module sbc_mode_props
  import sbc_pkg::*;
#(
  parameter int unsigned RST_STRETCH_CYC = SBC_RST_STRETCH_CYC,
  parameter int unsigned NREQ_CYC        = SBC_NREQ_CYC
) (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       mode_cmd_valid,
  input wire logic [1:0] mode_select_bits,
  input wire logic       isr_read,
  input wire logic       rst_pin_i,
  input wire logic       regulator_overtemp,
  input wire sbc_mode_e  mode_q,
  input wire logic       rst_pin_oe,
  input wire logic       irq_n_q,
  input wire logic       regulator_overtemp_flag,
  input wire logic       regulator_on_q,
  input wire logic       lin_rx_only_q,
  input wire logic       lin_tx_en_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic [31:0] oe_cnt_q;
  logic [31:0] nreq_cnt_q;
  ////////////////////////////////////////////////////////////////////////////
  // run lengths: reset drive and one request visit, cleared on exit
  always_ff @(posedge clk) begin
    oe_cnt_q   <= (srst || !rst_pin_oe) ? 32'h0 : oe_cnt_q + 32'h1;
    nreq_cnt_q <= (srst || mode_q != SBC_NREQ) ? 32'h0 : nreq_cnt_q + 32'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  stop_by_cmd_a: assert property (
    mode_q == SBC_STOP && $past(mode_q) != SBC_STOP |->
      $past(mode_cmd_valid) && $past(mode_select_bits) == SBC_CMD_STOP)
    else $error("stop entered without stop command");
  stop_exit_a: assert property (
    $past(mode_q) == SBC_STOP && mode_q != SBC_STOP |->
      mode_q inside {SBC_NREQ, SBC_NORMAL, SBC_RESET})
    else $error("stop left to a wrong mode");
  irq_mode_a: assert property (
    $fell(irq_n_q) |->
      $past(mode_q) inside {SBC_NREQ, SBC_NORMAL, SBC_STOP} &&
      !$past(rst_pin_oe))
    else $error("irq raised in a wrong mode");
  irq_hold_a: assert property (
    !irq_n_q && !isr_read && !rst_pin_oe &&
      mode_q inside {SBC_NREQ, SBC_NORMAL, SBC_STOP} |=> !irq_n_q)
    else $error("irq released without source read");
  irq_ack_a: assert property (
    $rose(irq_n_q) |-> $past(isr_read) || $past(srst) ||
      $past(rst_pin_oe) || mode_q inside {SBC_RESET, SBC_SLEEP})
    else $error("irq rose without source read");
  stretch_min_a: assert property (
    $fell(rst_pin_oe) |-> oe_cnt_q >= RST_STRETCH_CYC)
    else $error("reset drive shorter than stretch");
  nreq_limit_a: assert property (mode_q == SBC_NREQ |-> nreq_cnt_q <= NREQ_CYC)
    else $error("request mode outlived its timeout");
  ext_release_a: assert property (
    mode_q == SBC_RESET && !rst_pin_oe && $rose(rst_pin_i) |->
      ##[1:8] mode_q != SBC_RESET)
    else $error("external reset release was stretched");
  ovt_flag_a: assert property (
    $rose(regulator_overtemp) |->
      ##[1:2] regulator_overtemp_flag && !regulator_on_q)
    else $error("overtemp did not flag and stop regulator");
  rx_only_a: assert property (
    mode_q == SBC_NREQ && $past(mode_q) == SBC_NREQ |->
      lin_rx_only_q && !lin_tx_en_q)
    else $error("lin transmits in request mode");
endmodule : sbc_mode_props

`default_nettype wire

/* sbc_host_model.sv */
// host side model: mode commands, source reads, chip select, reset pull
`timescale 1ns/1ps
`default_nettype none

module sbc_host_model (
  input  wire logic clk,
  output logic      mode_cmd_valid,
  output logic [1:0] mode_select_bits,
  output logic      timing_control_wr,
  output logic      isr_read,
  output logic      cs_n,
  output logic      rst_low
);
  ////////////////////////////////////////////////////////////////////////////
  // idle host: no strobes, chip select high, reset pin released
  initial begin
    mode_cmd_valid    = 1'b0;
    mode_select_bits  = 2'h3;
    timing_control_wr = 1'b0;
    isr_read          = 1'b0;
    cs_n              = 1'b1;
    rst_low           = 1'b0;
  end
  // stop, sleep and service only ever come from here
  task automatic cmd(input logic [1:0] sel);
    @(posedge clk);
    #1 mode_cmd_valid = 1'b1;
    mode_select_bits = sel;
    @(posedge clk);
    #1 mode_cmd_valid = 1'b0;
    mode_select_bits = ~sel; // stale code must not matter
  endtask : cmd
  // timing write ahead of the normal command
  task automatic tim_wr;
    @(posedge clk);
    #1 timing_control_wr = 1'b1;
    @(posedge clk);
    #1 timing_control_wr = 1'b0;
  endtask : tim_wr
  // source read is the only irq acknowledge
  task automatic rd_isr;
    @(posedge clk);
    #1 isr_read = 1'b1;
    @(posedge clk);
    #1 isr_read = 1'b0;
  endtask : rd_isr
  // select pulse; the rising end is the wake event
  task automatic cs_wake;
    @(posedge clk);
    #1 cs_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 cs_n = 1'b1;
  endtask : cs_wake
  // caller holds the pin well past the glitch filter
  task automatic pull_rst(input logic low);
    @(posedge clk);
    #1 rst_low = low;
  endtask : pull_rst
endmodule : sbc_host_model

`default_nettype wire

/* sbc_mode_wake_reset_control_tb.sv */
// self-checking testbench of the mode sequencer
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end

module sbc_mode_wake_reset_control_tb;
  import sbc_pkg::*;
  logic clk = 1'b0, srst = 1'b1, regulator_reset_level = 1'b0;
  logic regulator_overtemp = 1'b0;
  logic [5:0] flt = 6'h00, irq_mask_reg = 6'h00;
  logic [3:0] wake_inputs = 4'h0, wake_control_reg = 4'hf;
  logic [1:0] wk = 2'h0;
  logic mode_cmd_valid, timing_control_wr, isr_read, cs_n, rst_low;
  logic rst_pin_oe, irq_n_q, regulator_overtemp_flag;
  logic [1:0] mode_select_bits;
  logic [11:0] wake_irq_source_reg;
  logic [3:0] wake_status_reg;
  sbc_mode_e mode_q;
  wire logic rst_pin_i;
  wire logic [6:0] ctl;
  int failures = 0, total_checks = 0;
  // open-drain reset wire with pull-up: low if either side pulls
  assign rst_pin_i = !(rst_pin_oe || rst_low);
  always #2 clk = ~clk;

  sbc_host_model host (.clk(clk), .mode_cmd_valid(mode_cmd_valid),
    .mode_select_bits(mode_select_bits), .timing_control_wr(timing_control_wr),
    .isr_read(isr_read), .cs_n(cs_n), .rst_low(rst_low));

  sbc_mode_ctrl #(.RST_STRETCH_CYC(20), .NREQ_CYC(200), .WD_CYC(100),
    .VDD_LOW_CYC(50), .GLITCH_CYC(4)) dut (.clk(clk), .srst(srst),
    .mode_cmd_valid(mode_cmd_valid), .mode_select_bits(mode_select_bits),
    .timing_control_wr(timing_control_wr), .isr_read(isr_read),
    .irq_mask_reg(irq_mask_reg), .wake_control_reg(wake_control_reg),
    .amux_input_sel(4'h0), .watchdog_config_pin(1'b0),
    .wake_inputs(wake_inputs), .lin_wake(wk[0]), .timer_wake(wk[1]),
    .cs_n(cs_n), .rst_pin_i(rst_pin_i),
    .regulator_reset_level(regulator_reset_level),
    .regulator_overtemp(regulator_overtemp), .regulator_prewarn(flt[2]),
    .supply_undervolt_level(flt[0]), .supply_overvolt_level(flt[1]),
    .lin_overtemp(flt[3]), .lin_txd_stuck(1'b0), .lin_rxd_short(1'b0),
    .lin_txd_recessive(1'b1), .high_side_overtemp(flt[4]),
    .low_side_overtemp(flt[5]), .mode_q(mode_q), .rst_pin_o(ctl[0]),
    .rst_pin_oe(rst_pin_oe), .irq_n_q(irq_n_q),
    .wake_irq_source_reg(wake_irq_source_reg),
    .wake_status_reg(wake_status_reg),
    .regulator_overtemp_flag(regulator_overtemp_flag), .regulator_on_q(ctl[1]),
    .regulator_limited_q(ctl[2]), .supply_monitor_q(ctl[3]),
    .lin_tx_en_q(ctl[4]), .lin_rx_only_q(ctl[5]),
    .lowpower_wake_only_q(ctl[6]));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // bounded wait; a miss shows up in the following compare
  task automatic wait_mode(input sbc_mode_e m, input int n);
    for (int i = 0; i < n && mode_q !== m; i++) tick(1);
  endtask : wait_mode
  task automatic to_normal;
    wait_mode(SBC_NREQ, 300);
    host.tim_wr();
    host.cmd(SBC_CMD_NORMAL);
    `CHK(mode_q, SBC_NORMAL)
  endtask : to_normal
  task automatic results;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  // hang guard, well past the expected run
  initial begin
    #40000;
    failures++;
    results();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(12);
    srst = 1'b0;
    wait_mode(SBC_NREQ, 100);
    tick(1);
    `CHK(rst_pin_oe, 1'b0)
    wait_mode(SBC_RESET, 210);
    `CHK(mode_q, SBC_RESET)
    $display("power-up and request timeout done");
    to_normal();
    host.cmd(SBC_CMD_NORMAL); // service while window still closed
    wait_mode(SBC_RESET, 4);
    `CHK(mode_q, SBC_RESET)
    wait_mode(SBC_NREQ, 100);
    host.rd_isr();
    for (int i = 0; i < 6; i++) begin
      flt = 6'h01 << i;
      tick(3);
      `CHK(wake_irq_source_reg[SBC_SRC_FLT+i], 1'b1)
      `CHK(irq_n_q, 1'b0)
      flt = 6'h00;
      host.rd_isr();
      `CHK(irq_n_q, 1'b1)
    end
    irq_mask_reg = 6'h3f; // masked fault must stay quiet
    flt = 6'h02;
    tick(3);
    `CHK(irq_n_q, 1'b1)
    flt = 6'h00;
    irq_mask_reg = 6'h00;
    $display("watchdog and fault irq done");
    to_normal();
    tick(60);
    host.cmd(SBC_CMD_NORMAL);
    `CHK(mode_q, SBC_NORMAL)
    `CHK(ctl, 7'h1a)
    wake_control_reg = 4'he; // input 0 may not wake
    host.cmd(SBC_CMD_STOP);
    `CHK(mode_q, SBC_STOP)
    wake_inputs = 4'h1;
    tick(6);
    `CHK(mode_q, SBC_STOP)
    `CHK(ctl, 7'h66)
    `CHK(wake_status_reg, 4'h1)
    wake_inputs = 4'h3;
    wait_mode(SBC_NREQ, 10);
    tick(1);
    `CHK(irq_n_q, 1'b0)
    `CHK(wake_irq_source_reg[SBC_SRC_LX+1], 1'b1)
    host.rd_isr();
    `CHK(irq_n_q, 1'b1)
    to_normal();
    host.cmd(SBC_CMD_STOP);
    host.cs_wake();
    wait_mode(SBC_NREQ, 10);
    tick(2);
    `CHK(irq_n_q, 1'b1)
    `CHK(wake_irq_source_reg, SBC_SRC_RST)
    $display("stop wakes done");
    for (int k = 0; k < 2; k++) begin
      to_normal();
      host.cmd(SBC_CMD_SLEEP);
      host.cs_wake();
      tick(6);
      `CHK(mode_q, SBC_SLEEP)
      `CHK(ctl, 7'h40)
      wk = 2'h1 << k;
      tick(1);
      wk = 2'h0;
      wait_mode(SBC_RESET, 10);
      tick(1);
      `CHK(rst_pin_oe, 1'b1)
      `CHK(irq_n_q, 1'b1)
      `CHK(wake_irq_source_reg[SBC_SRC_LIN_WAKE+k], 1'b1)
    end
    $display("sleep wakes done");
    host.rd_isr();
    to_normal();
    host.cmd(SBC_CMD_STOP);
    host.pull_rst(1'b1);
    tick(10);
    `CHK(mode_q, SBC_RESET)
    `CHK(rst_pin_oe, 1'b0)
    host.pull_rst(1'b0);
    wait_mode(SBC_NREQ, 10);
    `CHK(mode_q, SBC_NREQ)
    `CHK(irq_n_q, 1'b1)
    regulator_reset_level = 1'b1;
    flt = 6'h01;
    tick(3);
    `CHK(rst_pin_oe, 1'b1)
    regulator_overtemp = 1'b1;
    tick(3);
    `CHK(regulator_overtemp_flag, 1'b1)
    $display("external reset and regulator done");
    results();
  end
endmodule : sbc_mode_wake_reset_control_tb

bind sbc_mode_ctrl sbc_mode_props #(.RST_STRETCH_CYC(RST_STRETCH_CYC),
  .NREQ_CYC(NREQ_CYC)) u_props (.clk(clk), .srst(srst),
  .mode_cmd_valid(mode_cmd_valid), .mode_select_bits(mode_select_bits),
  .isr_read(isr_read), .rst_pin_i(rst_pin_i),
  .regulator_overtemp(regulator_overtemp), .mode_q(mode_q),
  .rst_pin_oe(rst_pin_oe), .irq_n_q(irq_n_q),
  .regulator_overtemp_flag(regulator_overtemp_flag),
  .regulator_on_q(regulator_on_q), .lin_rx_only_q(lin_rx_only_q),
  .lin_tx_en_q(lin_tx_en_q));

`default_nettype wire
